// ---- core/strap_pkg.sv ----
// Constants, offsets and types shared by the strap sampling and decode block
package strap_pkg;
  localparam int NUM_STRAPS = 13;
  localparam int NUM_LEDS = 10;
  // Strap pin positions inside the strap vector
  localparam int S_P1_LED_A = 0;
  localparam int S_P1_LED_B = 1;
  localparam int S_P2_LED_A = 2;
  localparam int S_P2_LED_B = 3;
  localparam int S_P3_LED_B = 4;
  localparam int S_P4_LED_A = 5;
  localparam int S_P4_LED_B = 6;
  localparam int S_P5_LED_B = 7;
  localparam int S_P6_RX_BIT0 = 8;
  localparam int S_P6_RX_BIT1 = 9;
  localparam int S_P6_RX_BIT2 = 10;
  localparam int S_P6_RX_BIT3 = 11;
  localparam int S_INBAND = 12;
  // Strap defaults, held until the first capture
  localparam logic [12:0] STRAP_RST = 13'h00FF;
  // Register byte offsets
  localparam logic [7:0] OFF_STRAPS = 8'h00;
  localparam logic [7:0] OFF_DECODE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_WAKE = 8'h0C;
  localparam logic [7:0] OFF_GPIO = 8'h10;
  // Control register fields and reset value
  localparam int CTRL_START = 0;
  localparam int CTRL_WAKE_POL = 1;
  localparam int CTRL_REF_SRC = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // General purpose pin control fields and reset value
  localparam int GPIO_SW_OUT = 0;
  localparam int GPIO_SW_OE = 1;
  localparam int GPIO_TIMER_SEL = 2;
  localparam int GPIO_PIN_IN = 3;
  localparam logic [2:0] GPIO_RST = 3'h0;
  // Bit position of the capture-done flag in the strap register
  localparam int STAT_SAMPLED = 16;
  // Two-bit strap encodings
  localparam logic [1:0] LN_RESERVED = 2'h0;
  localparam logic [1:0] LN_AN_OFF = 2'h1;
  localparam logic [1:0] LN_NAND = 2'h2;
  localparam logic [1:0] LN_AN_ON = 2'h3;
  typedef enum logic [1:0] {MGMT_MDIO, MGMT_I2C, MGMT_SPI} mgmt_t;
  typedef enum logic [1:0] {P6_RGMII, P6_RMII, P6_RSVD, P6_MII} p6_mode_t;
endpackage

// ---- core/strap_sampling_decode.sv ----
// Strap capture at reset release, strap decode and miscellaneous pin control
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module strap_sampling_decode (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [12:0] STRAP_IN,
  output logic [12:0] STRAP_OUT,
  output logic [12:0] STRAP_OE_N,
  output logic P3_LED_A_N,
  output logic P5_LED_A_N,
  input wire logic [9:0] LED_ON,
  input wire logic [3:0] P6_RXD,
  output logic FILTER_EN,
  output logic FLOW_CTRL_EN,
  output logic FAST_LINKUP,
  output logic AUTONEG_EN,
  output logic NAND_TREE,
  output logic FULL_DUPLEX,
  output logic STRAIGHT_WIRING,
  output logic [1:0] MGMT_SEL,
  output logic FORWARD_EN,
  output logic [1:0] P6_MODE,
  output logic P6_MAC_ROLE,
  output logic P6_REFCLK_OUT_EN,
  output logic P6_SPEED_1G,
  output logic INBAND_MGMT_EN,
  input wire logic ENERGY_EVENT,
  output logic WAKE_EVENT_OUT,
  input wire logic IRQ_REQ,
  output logic IRQ_OUT_LOW_O,
  output logic IRQ_OUT_LOW_OE_N,
  input wire logic GPIO_I,
  output logic GPIO_O,
  output logic GPIO_OE_N,
  input wire logic TIMER_GPIO_OUT,
  input wire logic TIMER_GPIO_OE,
  output logic TIMER_GPIO_IN,
  input wire logic RECOV_TICK,
  output logic SYNC_REF_CLK_OUT
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [12:0] strap_meta_q;
  logic [12:0] strap_sync_q;
  logic [12:0] strap_q;
  logic sampled_q;
  logic [12:0] pin_out_q;
  logic [12:0] pin_oe_n_q;
  logic [12:0] pin_norm;
  logic p3_led_q;
  logic p5_led_q;
  logic gpio_meta_q;
  logic gpio_sync_q;
  logic [2:0] ctrl_q;
  logic [2:0] gpio_ctrl_q;
  logic wake_pend_q;
  logic wake_pend_d;
  logic wake_out_q;
  logic irq_oe_n_q;
  logic gpio_out_q;
  logic gpio_oe_n_q;
  logic ref_clk_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic bus_req;
  logic bus_wr;
  logic hit_straps;
  logic hit_decode;
  logic hit_ctrl;
  logic hit_wake;
  logic hit_gpio;
  logic [31:0] rdata_d;
  logic fast;
  logic [1:0] ln_code;
  logic [1:0] mgmt_d;
  logic [1:0] p6_mode_d;
  logic autoneg_d;
  logic nand_d;
  logic straight_d;
  logic refclk_en_d;
  logic speed_1g_d;
  logic forward_d;
  logic [15:0] decode_vec;
  logic filter_q;
  logic flow_q;
  logic fast_q;
  logic autoneg_q;
  logic nand_q;
  logic straight_q;
  logic [1:0] mgmt_q;
  logic forward_q;
  logic [1:0] p6_mode_q;
  logic p6_role_q;
  logic refclk_en_q;
  logic speed_q;
  logic inband_q;
  logic gpio_drive;
  logic gpio_oe;
  logic ref_toggle;

  // Reset release through two flip-flops
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Strap and pin synchronisers keep sampling through reset
  always_ff @(posedge MCLK) begin
    strap_meta_q <= STRAP_IN;
    strap_sync_q <= strap_meta_q;
    gpio_meta_q <= GPIO_I;
    gpio_sync_q <= gpio_meta_q;
  end

  // One capture at the first edge after release
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sampled_q <= 1'b0;
      strap_q <= strap_pkg::STRAP_RST;
    end else if (!sampled_q) begin
      sampled_q <= 1'b1;
      strap_q <= strap_sync_q;
    end
  end

  // Normal function of each strap pin
  assign pin_norm = {strap_q[strap_pkg::S_INBAND], P6_RXD,
                     ~LED_ON[9], ~LED_ON[7], ~LED_ON[6], ~LED_ON[5],
                     ~LED_ON[3], ~LED_ON[2], ~LED_ON[1], ~LED_ON[0]};

  genvar gi;
  generate
    for (gi = 0; gi < strap_pkg::NUM_STRAPS; gi++) begin : g_pin
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          pin_oe_n_q[gi] <= 1'b1;
          pin_out_q[gi] <= 1'b1;
        end else begin
          pin_oe_n_q[gi] <= ~sampled_q;
          pin_out_q[gi] <= pin_norm[gi];
        end
      end
    end
  endgenerate

  // Strap decode
  assign fast = ~strap_q[strap_pkg::S_P2_LED_B];
  assign ln_code = {strap_q[strap_pkg::S_P2_LED_A], strap_q[strap_pkg::S_P4_LED_A]};
  assign autoneg_d = ~fast && (ln_code == strap_pkg::LN_AN_ON);
  assign nand_d = ~fast && (ln_code == strap_pkg::LN_NAND);
  assign straight_d = fast ? strap_q[strap_pkg::S_P2_LED_A] : 1'b1;
  assign mgmt_d = strap_q[strap_pkg::S_P4_LED_B] ? strap_pkg::MGMT_SPI :
                  (strap_q[strap_pkg::S_P3_LED_B] ? strap_pkg::MGMT_I2C :
                   strap_pkg::MGMT_MDIO);
  assign p6_mode_d = {strap_q[strap_pkg::S_P6_RX_BIT3],
                      strap_q[strap_pkg::S_P6_RX_BIT2]};
  assign refclk_en_d = (p6_mode_d == strap_pkg::P6_RMII) &&
                       !strap_q[strap_pkg::S_P6_RX_BIT1];
  assign speed_1g_d = !strap_q[strap_pkg::S_P6_RX_BIT0] &&
                      (p6_mode_d == strap_pkg::P6_RGMII);
  assign forward_d = strap_q[strap_pkg::S_P5_LED_B] ||
                     ctrl_q[strap_pkg::CTRL_START];
  assign decode_vec = {1'b0, inband_q, speed_q, refclk_en_q, p6_role_q, p6_mode_q,
                       forward_q, mgmt_q, straight_q, nand_q, autoneg_q, fast_q, flow_q,
                       filter_q};

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      filter_q <= 1'b0;
      flow_q <= 1'b1;
      fast_q <= 1'b0;
      autoneg_q <= 1'b1;
      nand_q <= 1'b0;
      straight_q <= 1'b1;
      mgmt_q <= strap_pkg::MGMT_SPI;
      forward_q <= 1'b0;
      p6_mode_q <= strap_pkg::P6_RGMII;
      p6_role_q <= 1'b0;
      refclk_en_q <= 1'b0;
      speed_q <= 1'b1;
      inband_q <= 1'b0;
    end else begin
      filter_q <= ~strap_q[strap_pkg::S_P1_LED_A];
      flow_q <= strap_q[strap_pkg::S_P1_LED_B];
      fast_q <= fast;
      autoneg_q <= autoneg_d;
      nand_q <= nand_d;
      straight_q <= straight_d;
      mgmt_q <= mgmt_d;
      forward_q <= forward_d && sampled_q;
      p6_mode_q <= p6_mode_d;
      p6_role_q <= strap_q[strap_pkg::S_P6_RX_BIT1];
      refclk_en_q <= refclk_en_d;
      speed_q <= speed_1g_d;
      inband_q <= strap_q[strap_pkg::S_INBAND];
    end
  end

  // Register bus decode
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_q;
  assign bus_wr = bus_req && WB_WE_I && WB_SEL_I[0];
  assign hit_straps = WB_ADR_I[7:2] == strap_pkg::OFF_STRAPS[7:2];
  assign hit_decode = WB_ADR_I[7:2] == strap_pkg::OFF_DECODE[7:2];
  assign hit_ctrl = WB_ADR_I[7:2] == strap_pkg::OFF_CTRL[7:2];
  assign hit_wake = WB_ADR_I[7:2] == strap_pkg::OFF_WAKE[7:2];
  assign hit_gpio = WB_ADR_I[7:2] == strap_pkg::OFF_GPIO[7:2];
  assign rdata_d = hit_straps ? {15'h0000, sampled_q, 3'h0, strap_q} :
                   hit_decode ? {16'h0000, decode_vec} :
                   hit_ctrl ? {29'h00000000, ctrl_q} :
                   hit_wake ? {31'h00000000, wake_pend_q} :
                   hit_gpio ? {28'h0000000, gpio_sync_q, gpio_ctrl_q} : 32'h00000000;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ctrl_q <= strap_pkg::CTRL_RST;
      gpio_ctrl_q <= strap_pkg::GPIO_RST;
    end else begin
      ack_q <= bus_req;
      rdata_q <= bus_req ? rdata_d : 32'h00000000;
      if (bus_wr && hit_ctrl) begin
        ctrl_q <= WB_DAT_I[2:0];
      end
      if (bus_wr && hit_gpio) begin
        gpio_ctrl_q <= WB_DAT_I[2:0];
      end
    end
  end

  // Wake event: sticky, write one to clear, set wins
  assign wake_pend_d = ENERGY_EVENT ||
                       (wake_pend_q && !(bus_wr && hit_wake && WB_DAT_I[0]));
  // Pin drive selection for the general pin and reference clock
  assign gpio_drive = gpio_ctrl_q[strap_pkg::GPIO_TIMER_SEL] ? TIMER_GPIO_OUT :
                      gpio_ctrl_q[strap_pkg::GPIO_SW_OUT];
  assign gpio_oe = gpio_ctrl_q[strap_pkg::GPIO_TIMER_SEL] ? TIMER_GPIO_OE :
                   gpio_ctrl_q[strap_pkg::GPIO_SW_OE];
  assign ref_toggle = ctrl_q[strap_pkg::CTRL_REF_SRC] ? RECOV_TICK : 1'b1;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      wake_pend_q <= 1'b0;
      wake_out_q <= 1'b1;
      irq_oe_n_q <= 1'b1;
      gpio_out_q <= 1'b0;
      gpio_oe_n_q <= 1'b1;
      ref_clk_q <= 1'b0;
      p3_led_q <= 1'b1;
      p5_led_q <= 1'b1;
    end else begin
      wake_pend_q <= wake_pend_d;
      wake_out_q <= ~(wake_pend_q ^ ctrl_q[strap_pkg::CTRL_WAKE_POL]);
      irq_oe_n_q <= ~IRQ_REQ;
      gpio_out_q <= gpio_drive;
      gpio_oe_n_q <= ~gpio_oe;
      ref_clk_q <= ref_clk_q ^ ref_toggle;
      p3_led_q <= ~LED_ON[4];
      p5_led_q <= ~LED_ON[8];
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;
  assign STRAP_OUT = pin_out_q;
  assign STRAP_OE_N = pin_oe_n_q;
  assign P3_LED_A_N = p3_led_q;
  assign P5_LED_A_N = p5_led_q;
  assign FILTER_EN = filter_q;
  assign FLOW_CTRL_EN = flow_q;
  assign FAST_LINKUP = fast_q;
  assign AUTONEG_EN = autoneg_q;
  assign NAND_TREE = nand_q;
  assign FULL_DUPLEX = fast_q;
  assign STRAIGHT_WIRING = straight_q;
  assign MGMT_SEL = mgmt_q;
  assign FORWARD_EN = forward_q;
  assign P6_MODE = p6_mode_q;
  assign P6_MAC_ROLE = p6_role_q;
  assign P6_REFCLK_OUT_EN = refclk_en_q;
  assign P6_SPEED_1G = speed_q;
  assign INBAND_MGMT_EN = inband_q;
  assign WAKE_EVENT_OUT = wake_out_q;
  assign IRQ_OUT_LOW_O = 1'b0;
  assign IRQ_OUT_LOW_OE_N = irq_oe_n_q;
  assign GPIO_O = gpio_out_q;
  assign GPIO_OE_N = gpio_oe_n_q;
  assign TIMER_GPIO_IN = gpio_sync_q;
  assign SYNC_REF_CLK_OUT = ref_clk_q;

  chk_pins_float_reset: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !sampled_q |-> (pin_oe_n_q == 13'h1FFF))
    else $error("strap pin driven before capture");
  chk_strap_capture: assert property (@(posedge MCLK) disable iff (!rst_n)
    $rose(sampled_q) |-> (strap_q == $past(strap_sync_q)))
    else $error("strap value not taken from synchronised pins");
  chk_pins_drive_after: assert property (@(posedge MCLK) disable iff (!rst_n)
    sampled_q |=> (pin_oe_n_q == 13'h0000))
    else $error("strap pin not driven after capture");
  chk_led_low_on: assert property (@(posedge MCLK) disable iff (!rst_n)
    (sampled_q && LED_ON[0]) |=> !STRAP_OUT[0])
    else $error("led not driven low when on");
  chk_filter_decode: assert property (@(posedge MCLK) disable iff (!rst_n)
    $past(rst_n) |-> (FILTER_EN == !$past(strap_q[0])))
    else $error("filter enable mismatch");
  chk_flow_decode: assert property (@(posedge MCLK) disable iff (!rst_n)
    $past(rst_n) |-> (FLOW_CTRL_EN == $past(strap_q[1])))
    else $error("flow control mismatch");
  chk_autoneg_decode: assert property (@(posedge MCLK) disable iff (!rst_n)
    (strap_q[3] && strap_q[2] && strap_q[5]) |=> (AUTONEG_EN && !NAND_TREE))
    else $error("auto-negotiation decode wrong");
  chk_fast_wiring: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!strap_q[3] && !strap_q[2]) |=> (FULL_DUPLEX && !STRAIGHT_WIRING && !AUTONEG_EN))
    else $error("fast link-up decode wrong");
  chk_mgmt_decode: assert property (@(posedge MCLK) disable iff (!rst_n)
    strap_q[6] |=> (MGMT_SEL == 2'h2))
    else $error("management select wrong");
  chk_forward_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!strap_q[7] && !ctrl_q[0]) |=> !FORWARD_EN)
    else $error("forwarding before start");
  chk_speed_mii: assert property (@(posedge MCLK) disable iff (!rst_n)
    (strap_q[11] || strap_q[10]) |=> !P6_SPEED_1G)
    else $error("gigabit speed with MII or RMII");
  chk_wake_polarity: assert property (@(posedge MCLK) disable iff (!rst_n)
    (ENERGY_EVENT && !ctrl_q[1]) ##1 !ctrl_q[1] |=> !WAKE_EVENT_OUT)
    else $error("wake output not asserted low");
  chk_irq_drive: assert property (@(posedge MCLK) disable iff (!rst_n)
    IRQ_REQ |=> (!IRQ_OUT_LOW_OE_N && !IRQ_OUT_LOW_O))
    else $error("interrupt not pulled low");
  chk_strap_stable: assert property (@(posedge MCLK) disable iff (!rst_n)
    $past(sampled_q) |-> $stable(strap_q))
    else $error("strap value changed after capture");
endmodule // strap_sampling_decode
`default_nettype wire

// ---- bench/strap_board.sv ----
// Board strap resistors and system reset source facing the strap block
`timescale 1ns/100ps
`default_nettype none
module strap_board (
  input wire logic mclk,
  input wire logic rst_req,
  input wire logic [12:0] pull,
  input wire logic [12:0] pin_out,
  input wire logic [12:0] pin_oe_n,
  output logic arst_n,
  output logic [12:0] pin_level
);
  int por_cnt = 0;
  // Reset held low for 15 cycles from power-on, then on request
  always @(posedge mclk) begin
    if (por_cnt < 16) por_cnt <= por_cnt + 1;
    arst_n <= (por_cnt >= 15) && !rst_req;
  end
  // Resistors set each level unless the device drives the pin
  always_comb begin
    for (int i = 0; i < 13; i++) begin
      pin_level[i] = (pin_oe_n[i] === 1'b0) ? pin_out[i] : pull[i];
    end
  end
endmodule // strap_board
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for strap capture, decode and pin control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic MCLK = 1'b0;
  logic rst_req = 1'b0;
  logic [12:0] pull = 13'h00FF;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000, rdat;
  logic [9:0] led_on = 10'h000;
  logic [3:0] rxd = 4'h0;
  logic energy = 1'b0, irq_req = 1'b0, tmr_out = 1'b0, tmr_oe = 1'b0, tick = 1'b0;
  logic [31:0] rnd = 32'hA1A36A9A;
  int mismatches = 0, n_checks = 0;
  wire logic arst_n, ack, p3_led_n, p5_led_n, full_dup, wake_out, irq_o, irq_oe_n;
  wire logic gpio_o, gpio_oe_n, gpio_pin, tmr_in, ref_clk;
  wire logic [31:0] dat_o;
  wire logic [12:0] strap_in, strap_out, strap_oe_n;
  wire logic [14:0] dec_port;
  // Pull-up holds the general pin high while nobody drives it
  assign gpio_pin = (gpio_oe_n === 1'b0) ? gpio_o : 1'b1;

  initial begin
    forever #10 MCLK = ~MCLK;
  end

  strap_board board (.mclk(MCLK), .rst_req(rst_req), .pull(pull), .pin_out(strap_out),
    .pin_oe_n(strap_oe_n), .arst_n(arst_n), .pin_level(strap_in));

  strap_sampling_decode DUT (.MCLK(MCLK), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .STRAP_IN(strap_in), .STRAP_OUT(strap_out), .STRAP_OE_N(strap_oe_n),
    .P3_LED_A_N(p3_led_n), .P5_LED_A_N(p5_led_n), .LED_ON(led_on), .P6_RXD(rxd),
    .FILTER_EN(dec_port[0]), .FLOW_CTRL_EN(dec_port[1]), .FAST_LINKUP(dec_port[2]),
    .AUTONEG_EN(dec_port[3]), .NAND_TREE(dec_port[4]), .FULL_DUPLEX(full_dup),
    .STRAIGHT_WIRING(dec_port[5]), .MGMT_SEL(dec_port[7:6]), .FORWARD_EN(dec_port[8]),
    .P6_MODE(dec_port[10:9]), .P6_MAC_ROLE(dec_port[11]), .P6_REFCLK_OUT_EN(dec_port[12]),
    .P6_SPEED_1G(dec_port[13]), .INBAND_MGMT_EN(dec_port[14]), .ENERGY_EVENT(energy),
    .WAKE_EVENT_OUT(wake_out), .IRQ_REQ(irq_req), .IRQ_OUT_LOW_O(irq_o),
    .IRQ_OUT_LOW_OE_N(irq_oe_n), .GPIO_I(gpio_pin), .GPIO_O(gpio_o), .GPIO_OE_N(gpio_oe_n),
    .TIMER_GPIO_OUT(tmr_out), .TIMER_GPIO_OE(tmr_oe), .TIMER_GPIO_IN(tmr_in),
    .RECOV_TICK(tick), .SYNC_REF_CLK_OUT(ref_clk));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  function automatic logic [14:0] dec_exp(input logic [12:0] s);
    logic fast;
    logic [1:0] ln;
    logic [1:0] md;
    fast = ~s[3];
    ln = {s[2], s[5]};
    md = {s[11], s[10]};
    dec_exp = {s[12], ~s[8] && md == 2'h0, md == 2'h1 && ~s[9], s[9], md, s[7],
      s[6] ? 2'h2 : {1'b0, s[4]}, fast ? s[2] : 1'b1, ~fast && ln == strap_pkg::LN_NAND,
      ~fast && ln == strap_pkg::LN_AN_ON, fast, s[1], ~s[0]};
  endfunction

  function automatic logic [12:0] pin_exp(input logic [9:0] on, input logic [3:0] rx,
    input logic ib);
    pin_exp = {ib, rx, ~on[9], ~on[7], ~on[6], ~on[5], ~on[3], ~on[2], ~on[1], ~on[0]};
  endfunction

  task automatic check_vec(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t vector got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge MCLK);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    check_vec(rdat, exp);
  endtask

  task automatic jiggle(input int n, input logic ib);
    repeat (n) begin
      rnd = lfsr(rnd);
      led_on <= rnd[9:0];
      rxd <= rnd[13:10];
      @(posedge MCLK);
    end
    repeat (2) @(posedge MCLK);
    check_vec(strap_out, pin_exp(led_on, rxd, ib));
    check_bit(p3_led_n, ~led_on[4]);
    check_bit(p5_led_n, ~led_on[8]);
  endtask

  task automatic strap_case(input logic [12:0] s);
    rst_req <= 1'b1;
    pull <= ~s;
    repeat (4) @(posedge MCLK);
    check_vec(strap_oe_n, 13'h1FFF);
    pull <= s;
    repeat (4) @(posedge MCLK);
    rst_req <= 1'b0;
    repeat (8) @(posedge MCLK);
    check_vec(strap_oe_n, 13'h0000);
    check_vec(dec_port, dec_exp(s));
    check_bit(full_dup, ~s[3]);
    rd(strap_pkg::OFF_STRAPS, 32'h00010000 | s);
    rd(strap_pkg::OFF_DECODE, dec_exp(s));
    jiggle(8, s[12]);
    check_vec(dec_port, dec_exp(s));
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge MCLK);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    logic [12:0] hand [4];
    logic prev;
    hand = '{13'h0418, 13'h1F28, 13'h080C, 13'h1FFF};
    repeat (20) @(posedge MCLK);
    foreach (hand[i]) strap_case(hand[i]);
    repeat (10) begin
      rnd = lfsr(rnd);
      strap_case(rnd[12:0]);
    end
    strap_case(13'h0000);
    check_bit(wake_out, 1'b1);
    wb(1'b1, strap_pkg::OFF_CTRL, 32'h00000001);
    repeat (2) @(posedge MCLK);
    check_bit(dec_port[8], 1'b1);
    rd(strap_pkg::OFF_CTRL, 32'h00000001);
    wb(1'b1, strap_pkg::OFF_STRAPS, 32'h00001FFF);
    rd(strap_pkg::OFF_STRAPS, 32'h00010000);
    rd(8'h20, 32'h00000000);
    energy <= 1'b1;
    @(posedge MCLK);
    energy <= 1'b0;
    repeat (3) @(posedge MCLK);
    check_bit(wake_out, 1'b0);
    rd(strap_pkg::OFF_WAKE, 32'h00000001);
    wb(1'b1, strap_pkg::OFF_WAKE, 32'h00000001);
    repeat (2) @(posedge MCLK);
    check_bit(wake_out, 1'b1);
    wb(1'b1, strap_pkg::OFF_CTRL, 32'h00000003);
    repeat (2) @(posedge MCLK);
    check_bit(wake_out, 1'b0);
    energy <= 1'b1;
    @(posedge MCLK);
    energy <= 1'b0;
    repeat (3) @(posedge MCLK);
    check_bit(wake_out, 1'b1);
    irq_req <= 1'b1;
    repeat (3) @(posedge MCLK);
    check_bit(irq_oe_n, 1'b0);
    check_bit(irq_o, 1'b0);
    irq_req <= 1'b0;
    repeat (3) @(posedge MCLK);
    check_bit(irq_oe_n, 1'b1);
    wb(1'b1, strap_pkg::OFF_GPIO, 32'h00000003);
    repeat (4) @(posedge MCLK);
    check_bit(gpio_oe_n, 1'b0);
    rd(strap_pkg::OFF_GPIO, 32'h0000000B);
    wb(1'b1, strap_pkg::OFF_GPIO, 32'h00000005);
    tmr_oe <= 1'b1;
    repeat (5) @(posedge MCLK);
    check_bit(gpio_o, 1'b0);
    check_bit(tmr_in, 1'b0);
    tmr_oe <= 1'b0;
    repeat (5) @(posedge MCLK);
    check_bit(tmr_in, 1'b1);
    check_bit(gpio_oe_n, 1'b1);
    prev = ref_clk;
    @(posedge MCLK);
    check_bit(ref_clk, ~prev);
    wb(1'b1, strap_pkg::OFF_CTRL, 32'h00000005);
    repeat (3) @(posedge MCLK);
    prev = ref_clk;
    repeat (3) @(posedge MCLK);
    check_bit(ref_clk, prev);
    tick <= 1'b1;
    @(posedge MCLK);
    tick <= 1'b0;
    repeat (3) @(posedge MCLK);
    check_bit(ref_clk, ~prev);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
